//--- design/fple_blink_timer.sv
`timescale 1ns/1ns
module fple_blink_timer
(
  input  wire logic                              clk_sys_i,
  input  wire logic                              reset_i,
  input  wire logic [fple_pkg::SLOT_LEN_W-1:0]   slot_len_i,
  output logic      [2:0]                        slot_o
);

  logic [fple_pkg::SLOT_LEN_W-1:0] cnt;
  logic [fple_pkg::SLOT_LEN_W-1:0] len_m1;
  logic                            slot_end;

  // a zero length behaves as one cycle so the timer never stalls
  assign len_m1   = (slot_len_i == '0) ? '0 : slot_len_i - 28'h000_0001;
  assign slot_end = (cnt >= len_m1);

  // free-running cycle counter; a shortened length takes effect at once
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      cnt <= '0;
    else if (slot_end)
      cnt <= '0;
    else
      cnt <= cnt + 28'h000_0001;
  end

  // six slots make one blink period shared by every pattern
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      slot_o <= 3'h0;
    else if (slot_end)
      slot_o <= (slot_o == fple_pkg::BLINK_LAST_SLOT) ? 3'h0 : slot_o + 3'h1;
  end

endmodule

//--- design/fple_led_encoder.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
module fple_led_encoder
#(
  parameter logic [fple_pkg::SLOT_LEN_W-1:0] SLOT_CYCLES =
    fple_pkg::SLOT_LEN_W'(fple_pkg::BLINK_SLOT_CYCLES)
)
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  input  wire fple_pkg::fple_flags_t flags_i,
  input  wire logic [6:0]            fan_err_pct_i,
  input  wire logic                  main_output_enable_n_i,
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  output logic                       irq_o,
  output fple_pkg::fple_leds_t       leds_o
);

  // yellow while the slot lies inside the yellow share of the period
  function automatic logic in_yellow(input logic [2:0] slot, input logic [2:0] share);
    in_yellow = (slot < share);
  endfunction

  // lamp colours for one indication at one point of the blink period
  function automatic fple_pkg::fple_leds_t dc_pattern(input fple_pkg::fple_ind_t ind,
                                                       input logic [2:0] slot);
    fple_pkg::fple_leds_t p;
    logic                 y;
    p = '0;
    y = 1'b0;
    unique case (ind)
      fple_pkg::IND_DISABLED:
      begin
        p.dc_yellow = in_yellow(slot, fple_pkg::YEL_SLOTS_1_1);
      end
      fple_pkg::IND_STANDBY:
      begin
        y           = in_yellow(slot, fple_pkg::YEL_SLOTS_1_2);
        p.dc_yellow = y;
        p.dc_green  = ~y;
      end
      fple_pkg::IND_FAULT:
      begin
        p.dc_yellow = 1'b1;
      end
      fple_pkg::IND_OT_WARN:
      begin
        y           = in_yellow(slot, fple_pkg::YEL_SLOTS_2_1);
        p.dc_yellow = y;
        p.dc_green  = ~y;
      end
      fple_pkg::IND_FAN_MINOR:
      begin
        y           = in_yellow(slot, fple_pkg::YEL_SLOTS_1_1);
        p.dc_yellow = y;
        p.dc_green  = ~y;
      end
      fple_pkg::IND_NORMAL:
      begin
        p.dc_green  = 1'b1;
      end
      default:
      begin
        p = '0;
      end
    endcase
    dc_pattern = p;
  endfunction

  logic                              oe_n_meta;
  logic                              oe_n_sync;
  fple_pkg::fple_ind_t               ind;
  fple_pkg::fple_ind_t               next_ind;
  logic [2:0]                        slot;
  logic                              led_en;
  logic [fple_pkg::SLOT_LEN_W-1:0]   slot_len;
  logic [fple_pkg::IRQ_W-1:0]        irq_status;
  logic [fple_pkg::IRQ_W-1:0]        irq_mask;
  logic [fple_pkg::IRQ_W-1:0]        irq_event;
  logic                              uv_q;
  logic                              fan_major;
  logic                              fan_minor;
  logic                              fault_any;
  fple_pkg::fple_leds_t              next_leds;
  logic [31:0]                       state_word;

  // the enable comes from a pin, so it is synchronised before any use
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      oe_n_meta <= 1'b1;
      oe_n_sync <= 1'b1;
    end
    else
    begin
      oe_n_meta <= main_output_enable_n_i;
      oe_n_sync <= oe_n_meta;
    end
  end

  // fan thresholds are strict; exactly 15 % falls in neither band
  assign fan_major = (fan_err_pct_i > fple_pkg::FAN_MAJOR_PCT);
  assign fan_minor = (fan_err_pct_i > fple_pkg::FAN_MINOR_PCT) &&
                     (fan_err_pct_i < fple_pkg::FAN_MAJOR_PCT);

  // any of the shutdown-class conditions
  assign fault_any = flags_i.out_of_reg | flags_i.ot_shutdown | flags_i.ov_shutdown |
                     flags_i.oc_shutdown | fan_major;

  // first true condition wins; a high on the active-low enable pin means output off
  always_comb
  begin
    if (oe_n_sync)
      next_ind = fple_pkg::IND_DISABLED;
    else if (flags_i.hot_standby)
      next_ind = fple_pkg::IND_STANDBY;
    else if (fault_any)
      next_ind = fple_pkg::IND_FAULT;
    else if (flags_i.ot_warning)
      next_ind = fple_pkg::IND_OT_WARN;
    else if (fan_minor)
      next_ind = fple_pkg::IND_FAN_MINOR;
    else
      next_ind = fple_pkg::IND_NORMAL;
  end

  // indication register, reset to the disabled pattern until the pin settles
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      ind <= fple_pkg::IND_DISABLED;
    else
      ind <= next_ind;
  end

  // one shared period source keeps every blink pattern in step
  fple_blink_timer u_blink
  (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .slot_len_i (slot_len),
    .slot_o     (slot)
  );

  // lamp drive word; uv beats in-range so a conflicting report shows dark
  always_comb
  begin
    next_leds          = dc_pattern(ind, slot);
    next_leds.ac_green = flags_i.line_in_range & ~flags_i.line_uv;
    if (!led_en)
      next_leds = '0;
  end

  // lamps come from flops so no decode glitch reaches the panel
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      leds_o <= '0;
    else
      leds_o <= next_leds;
  end

  // control register: lamp enable
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      led_en <= fple_pkg::CTRL_LED_EN_RST;
    else if (wr_i && addr_i == fple_pkg::ADDR_CTRL)
      led_en <= wdata_i[fple_pkg::CTRL_LED_EN_BIT];
  end

  // blink slot length; period is six slots
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      slot_len <= SLOT_CYCLES;
    else if (wr_i && addr_i == fple_pkg::ADDR_SLOT_LEN)
      slot_len <= wdata_i[fple_pkg::SLOT_LEN_W-1:0];
  end

  // interrupt mask
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      irq_mask <= fple_pkg::IRQ_MASK_RST;
    else if (wr_i && addr_i == fple_pkg::ADDR_IRQ_MASK)
      irq_mask <= wdata_i[fple_pkg::IRQ_W-1:0];
  end

  // edge memory for the undervoltage report
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      uv_q <= 1'b0;
    else
      uv_q <= flags_i.line_uv;
  end

  // events: indication change, entry into the fault group, loss of ac line
  always_comb
  begin
    irq_event                              = '0;
    irq_event[fple_pkg::IRQ_IND_CHG_BIT]   = (next_ind != ind);
    irq_event[fple_pkg::IRQ_FAULT_BIT]     = (next_ind == fple_pkg::IND_FAULT) &&
                                             (ind != fple_pkg::IND_FAULT);
    irq_event[fple_pkg::IRQ_AC_LOST_BIT]   = flags_i.line_uv & ~uv_q;
  end

  // sticky status, write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      irq_status <= '0;
    else if (wr_i && addr_i == fple_pkg::ADDR_IRQ_STATUS)
      irq_status <= (irq_status & ~wdata_i[fple_pkg::IRQ_W-1:0]) | irq_event;
    else
      irq_status <= irq_status | irq_event;
  end

  // level interrupt while any unmasked bit stands
  assign irq_o = |(irq_status & irq_mask);

  // live view of the encoder for software
  always_comb
  begin
    state_word                                  = fple_pkg::RDATA_ZERO;
    state_word[fple_pkg::ST_OE_BIT]             = ~oe_n_sync;
    state_word[fple_pkg::ST_LEDS_LSB +: 3]      = leds_o;
    state_word[fple_pkg::ST_SLOT_LSB +: 3]      = slot;
    state_word[fple_pkg::ST_IND_LSB +: 6]       = ind;
  end

  // read data valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      rdata_o <= fple_pkg::RDATA_ZERO;
    else if (rd_i)
    begin
      unique case (addr_i)
        fple_pkg::ADDR_CTRL:
          rdata_o <= {31'h0000_0000, led_en};
        fple_pkg::ADDR_SLOT_LEN:
          rdata_o <= {4'h0, slot_len};
        fple_pkg::ADDR_STATE:
          rdata_o <= state_word;
        fple_pkg::ADDR_IRQ_STATUS:
          rdata_o <= {29'h0000_0000, irq_status};
        fple_pkg::ADDR_IRQ_MASK:
          rdata_o <= {29'h0000_0000, irq_mask};
        default:
          rdata_o <= fple_pkg::RDATA_ZERO;
      endcase
    end
    else
      rdata_o <= fple_pkg::RDATA_ZERO;
  end

endmodule

//--- design/fple_pkg.sv
package fple_pkg;

  // clock and blink timing
  localparam int unsigned CLK_FREQ_KHZ      = 125_000;
  localparam int unsigned BLINK_SLOT_MS     = 200;
  localparam int unsigned BLINK_SLOT_CYCLES = BLINK_SLOT_MS * CLK_FREQ_KHZ;
  localparam int unsigned SLOT_LEN_W        = 28;
  localparam logic [2:0]  BLINK_LAST_SLOT   = 3'h5;

  // yellow share of the six-slot period for each blinking pattern
  localparam logic [2:0]  YEL_SLOTS_1_1     = 3'h3;
  localparam logic [2:0]  YEL_SLOTS_1_2     = 3'h2;
  localparam logic [2:0]  YEL_SLOTS_2_1     = 3'h4;

  // fan regulation error thresholds in percent
  localparam logic [6:0]  FAN_MAJOR_PCT     = 7'h0f;
  localparam logic [6:0]  FAN_MINOR_PCT     = 7'h05;

  // register map, byte addresses
  localparam logic [7:0]  ADDR_CTRL         = 8'h00;
  localparam logic [7:0]  ADDR_SLOT_LEN     = 8'h04;
  localparam logic [7:0]  ADDR_STATE        = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h10;

  // control register fields and reset
  localparam int unsigned CTRL_LED_EN_BIT   = 0;
  localparam logic        CTRL_LED_EN_RST   = 1'b1;

  // state register fields
  localparam int unsigned ST_OE_BIT         = 0;
  localparam int unsigned ST_LEDS_LSB       = 1;
  localparam int unsigned ST_SLOT_LSB       = 4;
  localparam int unsigned ST_IND_LSB        = 8;

  // interrupt bits, same layout in status and mask
  localparam int unsigned IRQ_W             = 3;
  localparam int unsigned IRQ_IND_CHG_BIT   = 0;
  localparam int unsigned IRQ_FAULT_BIT     = 1;
  localparam int unsigned IRQ_AC_LOST_BIT   = 2;
  localparam logic [2:0]  IRQ_MASK_RST      = 3'h0;

  localparam logic [31:0] RDATA_ZERO        = 32'h0000_0000;

  // status flags delivered by the supply controller
  typedef struct packed {
    logic line_in_range;
    logic line_uv;
    logic hot_standby;
    logic out_of_reg;
    logic ot_shutdown;
    logic ov_shutdown;
    logic oc_shutdown;
    logic ot_warning;
  } fple_flags_t;

  // lamp drives, one bit per colour
  typedef struct packed {
    logic ac_green;
    logic dc_green;
    logic dc_yellow;
  } fple_leds_t;

  // dc indication chosen by precedence
  typedef enum logic [5:0] {
    IND_DISABLED  = 6'b00_0001,
    IND_STANDBY   = 6'b00_0010,
    IND_FAULT     = 6'b00_0100,
    IND_OT_WARN   = 6'b00_1000,
    IND_FAN_MINOR = 6'b01_0000,
    IND_NORMAL    = 6'b10_0000
  } fple_ind_t;

endpackage

//--- tb/fple_lamp_model.sv
`timescale 1ns/1ns
module fple_lamp_model
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 clear_i,
  input  wire fple_pkg::fple_leds_t leds_i,
  output int                        ac_on_o,
  output int                        dc_green_o,
  output int                        dc_yellow_o
);
  // lamps integrate light per cycle, so a colour ratio is a count over one period
  always_ff @(posedge clk_sys_i)
  begin
    if (clear_i)
    begin
      ac_on_o     <= 0;
      dc_green_o  <= 0;
      dc_yellow_o <= 0;
    end
    else
    begin
      ac_on_o     <= ac_on_o + int'(leds_i.ac_green);
      dc_green_o  <= dc_green_o + int'(leds_i.dc_green);
      dc_yellow_o <= dc_yellow_o + int'(leds_i.dc_yellow);
    end
  end
endmodule

//--- tb/fple_led_encoder_sva.sv
`timescale 1ns/1ns
module fple_led_encoder_sva
#(
  parameter logic [27:0] SLOT_CYCLES = 28'h000_0004
)
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_i,
  input  wire fple_pkg::fple_flags_t flags_i,
  input  wire logic [6:0]            fan_err_pct_i,
  input  wire logic                  main_output_enable_n_i,
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic [31:0]           rdata_o,
  input  wire logic                  irq_o,
  input  wire fple_pkg::fple_leds_t  leds_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  // condition groups; five held cycles cover the pin sync plus both registers
  wire logic on   = !main_output_enable_n_i;
  wire logic flt  = flags_i.out_of_reg | flags_i.ot_shutdown | flags_i.ov_shutdown
                  | flags_i.oc_shutdown | (fan_err_pct_i > 7'h0f);
  wire logic calm = on && !flags_i.hot_standby && !flt && !flags_i.ot_warning;
  wire logic mix  = leds_o.dc_green != leds_o.dc_yellow;

  property p_ac_on;
    !$past(reset_i) && flags_i.line_in_range && !flags_i.line_uv |=> leds_o.ac_green;
  endproperty
  a_ac_on: assert property (p_ac_on)
    else $error("ac lamp dark with line in range");
  property p_ac_off;
    flags_i.line_uv |=> !leds_o.ac_green;
  endproperty
  a_ac_off: assert property (p_ac_off)
    else $error("ac lamp lit during undervoltage");
  property p_disabled;
    main_output_enable_n_i [*5] |=> !leds_o.dc_green;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("green shown while output disabled");
  property p_fault;
    (on && !flags_i.hot_standby && flt) [*5] |=> leds_o.dc_yellow && !leds_o.dc_green;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault not solid yellow");
  property p_normal;
    (calm && fan_err_pct_i <= 7'h05) [*5] |=> leds_o.dc_green && !leds_o.dc_yellow;
  endproperty
  a_normal: assert property (p_normal)
    else $error("quiet state not solid green");
  property p_standby;
    (on && flags_i.hot_standby) [*5] |=> mix;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby shows not exactly one colour");
  property p_minor;
    (calm && fan_err_pct_i > 7'h05 && fan_err_pct_i < 7'h0f) [*5] |=> mix;
  endproperty
  a_minor: assert property (p_minor)
    else $error("minor fan error shows not exactly one colour");
  property p_rdata;
    !rd_i || addr_i > fple_pkg::ADDR_IRQ_MASK |=> rdata_o == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside a mapped read");
endmodule

bind fple_led_encoder fple_led_encoder_sva #(.SLOT_CYCLES(SLOT_CYCLES)) u_sva
(
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .flags_i(flags_i),
  .fan_err_pct_i(fan_err_pct_i), .main_output_enable_n_i(main_output_enable_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .leds_o(leds_o)
);

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic                  clk_sys_i = 1'b0;
  logic                  reset_i = 1'b1;
  fple_pkg::fple_flags_t flags_i = 8'h00;
  logic [6:0]            fan_err_pct_i = 7'h00;
  logic                  main_output_enable_n_i = 1'b1;
  logic [7:0]            addr_i = 8'h00;
  logic [31:0]           wdata_i = 32'h0000_0000;
  logic                  wr_i = 1'b0;
  logic                  rd_i = 1'b0;
  logic                  clr = 1'b0;
  logic [31:0]           rdata_o;
  logic                  irq_o;
  fple_pkg::fple_leds_t  leds_o;
  logic [31:0]           d;
  int                    ac;
  int                    grn;
  int                    yel;
  int                    err_count = 0;
  int                    tests_run = 0;
  // {pin, ac on, flags, fan, yellow, green}; counts are per 24-cycle period
  logic [39:0]           tbl [17] = '{40'h10_0000_0c00, 40'h10_1000_0c00, 40'h00_2000_0810,
    40'h00_3100_0810, 40'h00_1000_1800, 40'h00_0800_1800, 40'h00_0400_1800,
    40'h00_0200_1800, 40'h00_0010_1800, 40'h00_1100_1800, 40'h00_010a_1008,
    40'h00_0006_0c0c, 40'h00_000e_0c0c, 40'h00_000f_0018, 40'h00_4005_0018,
    40'h00_c005_0018, 40'h01_8000_0018};

  always #4 clk_sys_i = ~clk_sys_i;

  fple_led_encoder #(.SLOT_CYCLES(28'h000_0004)) u_dut
  (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .flags_i(flags_i),
    .fan_err_pct_i(fan_err_pct_i), .main_output_enable_n_i(main_output_enable_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .leds_o(leds_o)
  );

  fple_lamp_model u_lamps
  (
    .clk_sys_i(clk_sys_i), .clear_i(clr), .leds_i(leds_o),
    .ac_on_o(ac), .dc_green_o(grn), .dc_yellow_o(yel)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // a hang is cut well past the ~1000 cycles the sequence needs
  initial
  begin
    #100000;
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    chk(32'(leds_o), 32'h0000_0000);
    reset_i <= 1'b0;
    foreach (tbl[i])
    begin
      @(posedge clk_sys_i);
      main_output_enable_n_i <= tbl[i][36];
      flags_i <= tbl[i][31:24];
      fan_err_pct_i <= tbl[i][22:16];
      repeat (30) @(posedge clk_sys_i);
      clr <= 1'b1;
      @(posedge clk_sys_i);
      clr <= 1'b0;
      repeat (24) @(posedge clk_sys_i);
      #1 chk(32'(yel), 32'(tbl[i][15:8]));
      chk(32'(grn), 32'(tbl[i][7:0]));
      chk(32'(ac), tbl[i][32] ? 32'h0000_0018 : 32'h0000_0000);
    end
    rd_reg(fple_pkg::ADDR_STATE);
    chk(d & 32'h0000_3f0f, 32'h0000_200d);
    rd_reg(fple_pkg::ADDR_SLOT_LEN);
    chk(d, 32'h0000_0004);
    rd_reg(fple_pkg::ADDR_CTRL);
    chk(d, 32'h0000_0001);
    rd_reg(fple_pkg::ADDR_IRQ_MASK);
    chk(d, 32'h0000_0000);
    wr_reg(8'h14, 32'hffff_ffff);
    rd_reg(8'h14);
    chk(d, 32'h0000_0000);
    // sticky line-loss event: raise, mask, unmask, clear
    wr_reg(fple_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
    wr_reg(fple_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
    chk(32'(irq_o), 32'h0000_0000);
    @(posedge clk_sys_i);
    flags_i <= 8'hc0;
    repeat (3) @(posedge clk_sys_i);
    flags_i <= 8'h80;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(32'(irq_o), 32'h0000_0001);
    rd_reg(fple_pkg::ADDR_IRQ_STATUS);
    chk(d & 32'h0000_0004, 32'h0000_0004);
    wr_reg(fple_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    chk(32'(irq_o), 32'h0000_0000);
    wr_reg(fple_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
    chk(32'(irq_o), 32'h0000_0001);
    wr_reg(fple_pkg::ADDR_IRQ_STATUS, 32'h0000_0004);
    chk(32'(irq_o), 32'h0000_0000);
    complete_run();
  end
endmodule
